// ---- rtl/tss_pkg.sv ----
// Package of offsets, field positions and reset values for the touch status bank
package tss_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GEN_STATUS = 8'h02;
   localparam logic [7:0] ADDR_TOUCH_STATUS = 8'h03;
   localparam logic [7:0] ADDR_LAMP_STATUS = 8'h04;
   localparam logic [7:0] ADDR_NOISE_STATUS = 8'h0A;
   localparam logic [7:0] ADDR_DELTA1 = 8'h10;
   localparam logic [7:0] ADDR_DELTA2 = 8'h11;
   localparam logic [7:0] ADDR_DELTA3 = 8'h12;
   localparam logic [7:0] ADDR_SENS_CTRL = 8'h1F;
   localparam logic [7:0] ADDR_MAIN_CFG = 8'h20;
   localparam logic [7:0] ADDR_EXTRA_CFG = 8'h44;
   // Reset values
   localparam logic [7:0] RST_MAIN_CTRL = 8'h00;
   localparam logic [7:0] RST_SENS_CTRL = 8'h2F;
   localparam logic [7:0] RST_MAIN_CFG_EARLY = 8'hA0;
   localparam logic [7:0] RST_MAIN_CFG_LATER = 8'h20;
   localparam logic [7:0] RST_EXTRA_CFG = 8'h40;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // Main control fields
   localparam int MC_INT_BIT = 0;
   localparam int MC_DEEPEST_SLEEP_REQUEST_BIT = 4;
   localparam int MC_STBY_BIT = 5;
   localparam int MC_GAIN_LSB = 6;
   // General status fields
   localparam int GS_TOUCH_BIT = 0;
   localparam int GS_PATTERN_BIT = 1;
   localparam int GS_MANY_TOUCH_BLOCK_FLAG_BIT = 2;
   localparam int GS_LAMP_BIT = 4;
   // Sensitivity control fields
   localparam int SC_SENSE_LSB = 4;
   localparam int SC_SHIFT_LSB = 0;
   localparam logic [3:0] BASE_SHIFT_MAX = 4'h8;
   // Main configuration fields
   localparam int CF_MAXDUR_BIT = 3;
   localparam int CF_LOWFREQ_OFF_BIT = 4;
   localparam int CF_DIGFLOOR_OFF_BIT = 5;
   localparam int CF_TIMEOUT_BIT = 7;
   // Extra configuration fields
   localparam int CX_NO_RELEASE_BIT = 0;
   localparam int CX_RADIO_OFF_BIT = 2;
   localparam int CX_RADIO_ONLY_BIT = 3;
   localparam int CX_ALERT_POL_BIT = 6;
   // Channel count and delta width
   localparam int NUM_PADS = 3;
   localparam logic [7:0] DELTA_POS_MAX = 8'h7F;
   localparam logic [7:0] DELTA_NEG_MAX = 8'h80;
   localparam logic [7:0] DELTA_ZERO = 8'h00;
endpackage

// ---- rtl/tss_delta.sv ----
// One input's delta count: difference, sensitivity scaling and saturation
`timescale 1ns/1ps
module tss_delta #(
   parameter int CW = 16
) (
   input wire logic i_sys_clk,              // System clock
   input wire logic i_rst,                  // Synchronous reset, high
   input wire logic i_load,                 // Sensing cycle result ready
   input wire logic i_force_zero,           // Noise blanks this sample
   input wire logic [CW-1:0] i_raw,         // Measured count
   input wire logic [CW-1:0] i_base,        // Untouched base count
   input wire logic [2:0] i_sense,          // Sensitivity code
   output logic [7:0] o_delta_q             // Two's complement delta
);
   typedef struct packed {
      logic [7:0] delta;
   } tss_delta_st_t;

   tss_delta_st_t st_q, st_d;
   logic signed [CW:0] diff;
   logic signed [CW:0] scaled;

   // Difference unscaled at code 0, halving per step to 1/128 at code 7
   always_comb begin
      diff = $signed({1'b0, i_raw}) - $signed({1'b0, i_base});
      scaled = diff >>> i_sense; // RULE16
      st_d = st_q;
      if (i_load) begin // RULE14
         if (i_force_zero) begin
            st_d.delta = tss_pkg::DELTA_ZERO; // RULE10
         end else if (scaled > $signed((CW+1)'(127))) begin
            st_d.delta = tss_pkg::DELTA_POS_MAX; // RULE15
         end else if (scaled < $signed(-(CW+1)'(128))) begin
            st_d.delta = tss_pkg::DELTA_NEG_MAX; // RULE15
         end else begin
            st_d.delta = scaled[7:0];
         end
      end
   end

   // State register
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_delta_q = st_q.delta;
endmodule

// ---- rtl/tss_bank.sv ----
// Touch status, noise, delta, sensitivity and configuration register bank
// Operation
// RULE1 - Entering deep sleep clears all general, touch, lamp and noise flags.
// RULE2 - General status bit 4 reads one when any lamp-done flag is set.
// RULE3 - Bit 2 follows touch blocking by limiter; never sets interrupt pending.
// RULE4 - Bit 1 sets on pattern threshold; interrupts only with alert enable.
// RULE5 - Pattern flag stays set while its cause persists.
// RULE6 - General status bit 0 reads one when any pad touch flag is set.
// RULE7 - Pad flag clears on interrupt clear only once touch has gone.
// RULE8 - Lamp-done flags set on finished behaviour, clear on interrupt clear.
// RULE9 - No lamp-done flag for a lamp linked to a touch input.
// RULE10 - A noisy pad has its delta count forced to 00h.
// RULE11 - Noise flags follow the live noise report each sample, no latching.
// RULE12 - With pattern on, noisy pads count as over threshold, once each.
// RULE13 - Low-frequency or radio noise discards the sample unless filter off.
// RULE14 - Each delta register refreshes once per sensing cycle.
// RULE15 - Delta is 8-bit two's complement saturating at 7Fh and 80h.
// RULE16 - Sensitivity bits 6:4 scale 128x at 000b down to 1x, default 32x.
// RULE17 - Base shift bits 3:0 give 2^code, capped 256x, reset 1111b.
// RULE18 - Base shift changes only base presentation, not detection.
// RULE19 - Main configuration resets to A0h early, 20h later revision.
// RULE20 - Host writes zero to interrupt pending; alert drops, gone causes clear.
// RULE21 - Undefined addresses read 00h; writes to them do nothing.
// RULE22 - Writes to read-only status, noise and delta registers are ignored.
`timescale 1ns/1ps
module tss_bank #(
   parameter bit LATER_REV = 1'b1,  // Later functional revision
   parameter int CW = 16            // Raw and base count width
) (
   input wire logic i_sys_clk,                   // System clock, 125 MHz
   input wire logic i_rst,                       // Synchronous reset, high
   input wire logic [7:0] i_reg_addr,            // Register address
   input wire logic i_reg_wr,                    // Write strobe
   input wire logic [7:0] i_reg_wdata,           // Write data
   input wire logic i_reg_rd,                    // Read strobe
   input wire logic i_sample_valid,              // Sensing cycle done
   input wire logic [2:0][CW-1:0] i_raw_count,   // Measured counts
   input wire logic [2:0][CW-1:0] i_base_count,  // Base counts
   input wire logic [2:0] i_lf_noise,            // Low-frequency noise
   input wire logic [2:0] i_rf_noise,            // Radio noise
   input wire logic [2:0] i_touch_detect,        // New touch, pulse
   input wire logic [2:0] i_touch_present,       // Touch still held
   input wire logic i_many_touch_block_flag_block,                // Limiter suppressing
   input wire logic i_pattern_en,                // Pattern detection on
   input wire logic i_pattern_by_count,          // Count mode, else mask
   input wire logic [2:0] i_pattern_mask,        // Pattern pads
   input wire logic [1:0] i_pattern_count,       // Pads needed in count mode
   input wire logic [2:0] i_over_pattern_thr,    // Delta over pattern thr
   input wire logic i_pattern_alert_enable,      // Pattern raises interrupt
   input wire logic [2:0] i_lamp_finished,       // Lamp behaviour done
   input wire logic [2:0] i_lamp_linked,         // Lamp linked to pad
   output logic [7:0] o_reg_rdata,               // Read data
   output logic o_reg_rvalid,                    // Read data valid
   output logic o_alert_out,                     // Alert pin level
   output logic o_alert_oe,                      // Alert pin drive enable
   output logic o_deep_sleep,                    // Deep sleep active
   output logic o_standby,                       // Standby active
   output logic [1:0] o_gain,                    // Sensor gain code
   output logic [2:0] o_sense_code,              // Sensitivity code
   output logic [3:0] o_base_scale_log2,         // Base count shift
   output logic [7:0] o_main_cfg,                // Main configuration
   output logic [7:0] o_extra_cfg,               // Extra configuration
   output logic [2:0][7:0] o_delta               // Delta counts
);
   localparam logic [7:0] RST_MAIN_CFG = LATER_REV ?
      tss_pkg::RST_MAIN_CFG_LATER : tss_pkg::RST_MAIN_CFG_EARLY; // RULE19

   typedef struct packed {
      logic [7:0] main_ctrl;
      logic [7:0] sens;
      logic [7:0] cfg;
      logic [7:0] cfg2;
      logic [2:0] pad;
      logic [2:0] lamp;
      logic [2:0] noise;
      logic many_touch_block_flag;
      logic pattern;
      logic [7:0] rdata;
      logic rvalid;
      logic alert_out;
      logic alert_oe;
      logic [3:0] scale;
   } tss_state_t;

   tss_state_t st_q, st_d;
   logic [2:0][7:0] delta_q;
   logic [2:0] blank;
   logic [2:0] hot;
   logic pattern_cond;
   logic sleeping;
   logic int_clear;
   logic int_set;
   logic wr_ctrl;

   // Number of set bits among three
   function automatic logic [1:0] pop3(input logic [2:0] v);
      pop3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
   endfunction

   // Base presentation multiplier exponent, capped at 256x
   function automatic logic [3:0] base_log2(input logic [3:0] code);
      base_log2 = (code > tss_pkg::BASE_SHIFT_MAX) ?
         tss_pkg::BASE_SHIFT_MAX : code; // RULE17
   endfunction

   // General status view composed from the pad, pattern, limiter and lamp flags
   function automatic logic [7:0] gen_view(input tss_state_t s);
      gen_view = 8'h00;
      gen_view[tss_pkg::GS_TOUCH_BIT] = |s.pad; // RULE6
      gen_view[tss_pkg::GS_PATTERN_BIT] = s.pattern;
      gen_view[tss_pkg::GS_MANY_TOUCH_BLOCK_FLAG_BIT] = s.many_touch_block_flag;
      gen_view[tss_pkg::GS_LAMP_BIT] = |s.lamp; // RULE2
   endfunction

   // Noise blanking per pad: flag or unfiltered noise kills sample
   always_comb begin
      for (int i = 0; i < tss_pkg::NUM_PADS; i++) begin
         blank[i] = st_q.noise[i] // RULE10
            | (i_lf_noise[i] & ~st_q.cfg[tss_pkg::CF_LOWFREQ_OFF_BIT])
            | (i_rf_noise[i] & ~st_q.cfg2[tss_pkg::CX_RADIO_OFF_BIT]);
      end // RULE13
   end

   // Delta count per pad; base shift never reaches this path
   for (genvar g = 0; g < tss_pkg::NUM_PADS; g++) begin : g_delta
      tss_delta #(
         .CW(CW)
      ) u_delta (
         .i_sys_clk(i_sys_clk),
         .i_rst(i_rst),
         .i_load(i_sample_valid & ~sleeping),
         .i_force_zero(blank[g]),
         .i_raw(i_raw_count[g]),
         .i_base(i_base_count[g]),
         .i_sense(st_q.sens[tss_pkg::SC_SENSE_LSB +: 3]), // RULE18
         .o_delta_q(delta_q[g])
      );
   end

   // Pattern condition: noisy pads count as over threshold, once each
   always_comb begin
      hot = i_over_pattern_thr | st_q.noise; // RULE12
      if (!i_pattern_en) begin
         pattern_cond = 1'b0;
      end else if (i_pattern_by_count) begin
         pattern_cond = (pop3(hot) >= i_pattern_count) &&
            (i_pattern_count != 2'h0);
      end else begin
         pattern_cond = (i_pattern_mask != 3'h0) &&
            ((hot & i_pattern_mask) == i_pattern_mask);
      end
   end

   // Control decodes
   assign sleeping = st_q.main_ctrl[tss_pkg::MC_DEEPEST_SLEEP_REQUEST_BIT];
   assign wr_ctrl = i_reg_wr && (i_reg_addr == tss_pkg::ADDR_MAIN_CTRL);
   assign int_clear = wr_ctrl &&
      !i_reg_wdata[tss_pkg::MC_INT_BIT]; // RULE20
   assign int_set = !sleeping && (|i_touch_detect ||
      |(i_lamp_finished & ~i_lamp_linked) ||
      (pattern_cond && !st_q.pattern && i_pattern_alert_enable)); // RULE4

   // Next state: registers, flags, read path and alert pin
   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      // Writable registers; status and delta offsets are read only
      if (i_reg_wr) begin // RULE22
         unique case (i_reg_addr)
            tss_pkg::ADDR_MAIN_CTRL: begin
               st_d.main_ctrl = {i_reg_wdata[7:4], 3'h0,
                  i_reg_wdata[tss_pkg::MC_INT_BIT] &
                  st_q.main_ctrl[tss_pkg::MC_INT_BIT]};
            end
            tss_pkg::ADDR_SENS_CTRL: begin
               st_d.sens = {1'b0, i_reg_wdata[6:0]};
            end
            tss_pkg::ADDR_MAIN_CFG: begin
               st_d.cfg = i_reg_wdata & 8'hB8;
            end
            tss_pkg::ADDR_EXTRA_CFG: begin
               st_d.cfg2 = i_reg_wdata & 8'hFD;
            end
            default: begin
               st_d.cfg2 = st_d.cfg2; // RULE21
            end
         endcase
      end
      // Pad flags: set on touch, clear on interrupt clear once released
      for (int i = 0; i < tss_pkg::NUM_PADS; i++) begin
         if (int_clear && !i_touch_present[i]) begin
            st_d.pad[i] = 1'b0; // RULE7
         end
         if (i_touch_detect[i]) begin
            st_d.pad[i] = 1'b1;
         end
      end
      // Lamp-done flags; linked lamps never report
      if (int_clear) begin
         st_d.lamp = 3'h0; // RULE8
      end
      st_d.lamp = st_d.lamp | (i_lamp_finished & ~i_lamp_linked); // RULE9
      // Limiter flag tracks suppression and never touches interrupt
      st_d.many_touch_block_flag = i_many_touch_block_flag_block; // RULE3
      // Pattern flag held while cause persists
      if (int_clear && !pattern_cond) begin
         st_d.pattern = 1'b0; // RULE5
      end
      if (pattern_cond) begin
         st_d.pattern = 1'b1; // RULE4
      end
      // Noise flags follow each sample report
      if (i_sample_valid) begin
         st_d.noise = i_rf_noise | (i_lf_noise &
            {3{~st_q.cfg2[tss_pkg::CX_RADIO_ONLY_BIT]}}); // RULE11
      end
      // Interrupt pending: an event in the clearing cycle wins
      if (int_set) begin
         st_d.main_ctrl[tss_pkg::MC_INT_BIT] = 1'b1;
      end
      // Deep sleep wipes every flag and the pending interrupt
      if (st_d.main_ctrl[tss_pkg::MC_DEEPEST_SLEEP_REQUEST_BIT]) begin
         st_d.pad = 3'h0; // RULE1
         st_d.lamp = 3'h0;
         st_d.noise = 3'h0;
         st_d.many_touch_block_flag = 1'b0;
         st_d.pattern = 1'b0;
         st_d.main_ctrl[tss_pkg::MC_INT_BIT] = 1'b0;
      end
      // Read path, answered one cycle after the strobe
      if (i_reg_rd) begin
         st_d.rvalid = 1'b1;
         unique case (i_reg_addr)
            tss_pkg::ADDR_MAIN_CTRL: st_d.rdata = st_q.main_ctrl;
            tss_pkg::ADDR_GEN_STATUS: st_d.rdata = gen_view(st_q);
            tss_pkg::ADDR_TOUCH_STATUS: st_d.rdata = {5'h00, st_q.pad};
            tss_pkg::ADDR_LAMP_STATUS: st_d.rdata = {5'h00, st_q.lamp};
            tss_pkg::ADDR_NOISE_STATUS: st_d.rdata = {5'h00, st_q.noise};
            tss_pkg::ADDR_DELTA1: st_d.rdata = delta_q[0];
            tss_pkg::ADDR_DELTA2: st_d.rdata = delta_q[1];
            tss_pkg::ADDR_DELTA3: st_d.rdata = delta_q[2];
            tss_pkg::ADDR_SENS_CTRL: st_d.rdata = st_q.sens;
            tss_pkg::ADDR_MAIN_CFG: st_d.rdata = st_q.cfg;
            tss_pkg::ADDR_EXTRA_CFG: st_d.rdata = st_q.cfg2;
            default: st_d.rdata = tss_pkg::RD_UNMAPPED; // RULE21
         endcase
      end
      // Alert pin: open drain low when polarity bit set, else push-pull
      if (st_d.cfg2[tss_pkg::CX_ALERT_POL_BIT]) begin
         st_d.alert_out = 1'b0;
         st_d.alert_oe = st_d.main_ctrl[tss_pkg::MC_INT_BIT]; // RULE20
      end else begin
         st_d.alert_out = st_d.main_ctrl[tss_pkg::MC_INT_BIT];
         st_d.alert_oe = 1'b1;
      end
      st_d.scale = base_log2(st_d.sens[tss_pkg::SC_SHIFT_LSB +: 4]);
   end

   // State register
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         st_q.main_ctrl <= tss_pkg::RST_MAIN_CTRL;
         st_q.sens <= tss_pkg::RST_SENS_CTRL; // RULE16
         st_q.cfg <= RST_MAIN_CFG; // RULE19
         st_q.cfg2 <= tss_pkg::RST_EXTRA_CFG;
         st_q.pad <= 3'h0;
         st_q.lamp <= 3'h0;
         st_q.noise <= 3'h0;
         st_q.many_touch_block_flag <= 1'b0;
         st_q.pattern <= 1'b0;
         st_q.rdata <= 8'h00;
         st_q.rvalid <= 1'b0;
         st_q.alert_out <= 1'b0;
         st_q.alert_oe <= 1'b0;
         st_q.scale <= tss_pkg::BASE_SHIFT_MAX;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign o_reg_rdata = st_q.rdata;
   assign o_reg_rvalid = st_q.rvalid;
   assign o_alert_out = st_q.alert_out;
   assign o_alert_oe = st_q.alert_oe;
   assign o_deep_sleep = st_q.main_ctrl[tss_pkg::MC_DEEPEST_SLEEP_REQUEST_BIT];
   assign o_standby = st_q.main_ctrl[tss_pkg::MC_STBY_BIT];
   assign o_gain = st_q.main_ctrl[tss_pkg::MC_GAIN_LSB +: 2];
   assign o_sense_code = st_q.sens[tss_pkg::SC_SENSE_LSB +: 3];
   assign o_base_scale_log2 = st_q.scale;
   assign o_main_cfg = st_q.cfg;
   assign o_extra_cfg = st_q.cfg2;
   assign o_delta = delta_q;
endmodule

// ---- sim/tss_bank_asserts.sv ----
// Assertion checker for the touch status register bank
`timescale 1ns/1ps
module tss_bank_chk #(
   parameter bit LATER_REV = 1'b1, // Later revision
   parameter int CW = 16           // Count width
) (
   input wire logic i_sys_clk, // Clock
   input wire logic i_rst, // Reset
   input wire logic [7:0] i_reg_addr, // Address
   input wire logic i_reg_wr, // Write
   input wire logic [7:0] i_reg_wdata, // Write data
   input wire logic i_reg_rd, // Read
   input wire logic i_sample_valid, // Sample
   input wire logic [2:0] i_touch_detect, // New touch
   input wire logic i_pattern_alert_enable, // Pattern alert
   input wire logic [2:0] i_lamp_finished, // Lamp done
   input wire logic [2:0] i_lamp_linked, // Lamp linked
   input wire logic [7:0] o_reg_rdata, // Read data
   input wire logic o_reg_rvalid, // Read valid
   input wire logic o_alert_out, // Alert level
   input wire logic o_alert_oe, // Alert enable
   input wire logic o_deep_sleep, // Asleep
   input wire logic o_standby, // Standby
   input wire logic [1:0] o_gain, // Gain
   input wire logic [2:0] o_sense_code, // Sensitivity
   input wire logic [3:0] o_base_scale_log2, // Base shift
   input wire logic [7:0] o_main_cfg, // Main config
   input wire logic [7:0] o_extra_cfg, // Extra config
   input wire logic [2:0][7:0] o_delta // Deltas
);
   logic int_now;
   logic quiet;
   logic [7:0] wd_q;
   // Pending interrupt seen at the pin, and no event raising one
   assign int_now = o_extra_cfg[6] ? o_alert_oe : o_alert_out;
   assign quiet = (i_touch_detect == 3'h0) && !i_pattern_alert_enable
      && ((i_lamp_finished & ~i_lamp_linked) == 3'h0);
   // Write data input from the previous cycle, written or not
   always_ff @(posedge i_sys_clk) begin
      wd_q <= i_reg_wdata;
   end
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   // Host steps on the main control register
   sequence s_clr_int;
      i_reg_wr && i_reg_addr == 8'h00 && !i_reg_wdata[0] && quiet;
   endsequence
   sequence s_sleep;
      i_reg_wr && i_reg_addr == 8'h00 && i_reg_wdata[4];
   endsequence
   property p_rvalid;
      !i_reg_rd |=> !o_reg_rvalid;
   endproperty
   property p_rdata_hold;
      !i_reg_rd |=> $stable(o_reg_rdata);
   endproperty
   property p_unmapped;
      i_reg_rd && i_reg_addr == 8'h05 |=> o_reg_rvalid && o_reg_rdata == 8'h00;
   endproperty
   property p_int_clear;
      s_clr_int |=> !int_now;
   endproperty
   property p_quiet;
      !int_now && quiet && !i_reg_wr |=> !int_now;
   endproperty
   property p_sleep;
      s_sleep |=> o_deep_sleep && !int_now;
   endproperty
   property p_sense;
      i_reg_wr && i_reg_addr == 8'h1F |=> o_sense_code == wd_q[6:4]
         && o_base_scale_log2 == (wd_q[3] ? 4'h8 : wd_q[3:0]);
   endproperty
   property p_cfg_rst;
      $fell(i_rst) |-> o_main_cfg == (LATER_REV ? 8'h20 : 8'hA0);
   endproperty
   property p_delta_hold;
      !i_sample_valid |=> $stable(o_delta);
   endproperty
   property p_ctrl;
      i_reg_wr && i_reg_addr == 8'h00 |=> o_gain == wd_q[7:6]
         && o_standby == wd_q[5];
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("stray read valid");
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   a_int_clear: assert property (p_int_clear) else $error("alert");
   a_quiet: assert property (p_quiet) else $error("alert");
   a_sleep: assert property (p_sleep) else $error("sleep");
   a_sense: assert property (p_sense) else $error("scale");
   a_cfg_rst: assert property (p_cfg_rst) else $error("cfg");
   a_delta_hold: assert property (p_delta_hold) else $error("dl");
   a_ctrl: assert property (p_ctrl) else $error("ctrl");
endmodule
bind tss_bank tss_bank_chk #(.LATER_REV(LATER_REV), .CW(CW)) chk_u (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
   .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
   .i_sample_valid(i_sample_valid), .i_touch_detect(i_touch_detect),
   .i_pattern_alert_enable(i_pattern_alert_enable),
   .i_lamp_finished(i_lamp_finished), .i_lamp_linked(i_lamp_linked),
   .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe),
   .o_deep_sleep(o_deep_sleep), .o_sense_code(o_sense_code),
   .o_standby(o_standby), .o_gain(o_gain),
   .o_base_scale_log2(o_base_scale_log2), .o_main_cfg(o_main_cfg),
   .o_extra_cfg(o_extra_cfg), .o_delta(o_delta));

// ---- sim/tss_host.sv ----
// Host controller model driving the register port
`timescale 1ns/1ps
module tss_host (
   input wire logic i_sys_clk, // Clock
   output logic [7:0] o_reg_addr, // Address
   output logic o_reg_wr, // Write
   output logic [7:0] o_reg_wdata, // Write data
   output logic o_reg_rd, // Read
   input wire logic [7:0] i_reg_rdata, // Read data
   input wire logic i_reg_rvalid // Read valid
);
   // Idle bus at time zero
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd = 1'b0;
   end
   // One write; leftovers inverted so stale values never match
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_sys_clk);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_sys_clk);
      o_reg_wr = 1'b0;
      o_reg_addr = ~a;
      o_reg_wdata = ~d;
   endtask
   // One read; data only counts with the valid pulse
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_sys_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_sys_clk);
      o_reg_rd = 1'b0;
      o_reg_addr = ~a;
      d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hXX;
   endtask
   // Clear the pending interrupt
   task automatic clr_int();
      wr_reg(8'h00, 8'h00);
   endtask
endmodule

// ---- sim/tss_bank_test.sv ----
// Self-checking testbench for the touch status register bank
`timescale 1ns/1ps
module tss_bank_test;
   logic i_sys_clk, i_rst, wr, rd, rvalid, sv, many_touch_block_flag, pen, pcm, palert;
   logic [7:0] addr, wdata, rdata;
   logic [2:0][15:0] raw, base;
   logic [2:0] lf, rf, det, pres, pmask, over, lfin, llink;
   logic [1:0] pcnt;
   int error_cnt, comparisons, cyc;
   logic [7:0] ro [8] = '{8'h02, 8'h03, 8'h04, 8'h0A, 8'h10, 8'h11, 8'h12,
      8'h05};
   tss_bank dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
      .i_sample_valid(sv), .i_raw_count(raw), .i_base_count(base),
      .i_lf_noise(lf), .i_rf_noise(rf), .i_touch_detect(det),
      .i_touch_present(pres), .i_many_touch_block_flag_block(many_touch_block_flag), .i_pattern_en(pen),
      .i_pattern_by_count(pcm), .i_pattern_mask(pmask),
      .i_pattern_count(pcnt), .i_over_pattern_thr(over),
      .i_pattern_alert_enable(palert), .i_lamp_finished(lfin),
      .i_lamp_linked(llink), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .o_alert_out(), .o_alert_oe(), .o_deep_sleep(), .o_standby(),
      .o_gain(), .o_sense_code(), .o_base_scale_log2(), .o_main_cfg(),
      .o_extra_cfg(), .o_delta());
   tss_host host_u (.i_sys_clk(i_sys_clk), .o_reg_addr(addr), .o_reg_wr(wr),
      .o_reg_wdata(wdata), .o_reg_rd(rd), .i_reg_rdata(rdata),
      .i_reg_rvalid(rvalid));
   // Clock and hang limit
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         $display("[ERR] %0t run too long", $time);
         finish_test();
      end
   end
   task finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host_u.rd_reg(a, d);
      chk(d, e);
   endtask
   task samp;
      @(negedge i_sys_clk);
      sv = 1'b1;
      @(negedge i_sys_clk);
      sv = 1'b0;
   endtask
   task ev(input logic [2:0] d, input logic [2:0] l);
      @(negedge i_sys_clk);
      det = d;
      lfin = l;
      @(negedge i_sys_clk);
      det = 3'h0;
      lfin = 3'h0;
   endtask
   task t_reset;
      rd_chk(8'h1F, 8'h2F);
      rd_chk(8'h20, 8'h20);
      rd_chk(8'h44, 8'h40);
      for (int i = 0; i < 8; i++) begin
         host_u.wr_reg(ro[i], 8'hFF);
         rd_chk(ro[i], 8'h00);
      end
      $display("reset and read-only test done");
   endtask
   task t_touch;
      pres = 3'b010;
      ev(3'b010, 3'b000);
      rd_chk(8'h03, 8'h02);
      rd_chk(8'h02, 8'h01);
      rd_chk(8'h00, 8'h01);
      host_u.clr_int();
      rd_chk(8'h03, 8'h02);
      rd_chk(8'h00, 8'h00);
      pres = 3'b000;
      host_u.clr_int();
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h02, 8'h00);
      $display("touch test done");
   endtask
   task t_lamp_many_touch_block_flag;
      llink = 3'b100;
      ev(3'b000, 3'b101);
      rd_chk(8'h04, 8'h01);
      rd_chk(8'h02, 8'h10);
      host_u.clr_int();
      rd_chk(8'h04, 8'h00);
      many_touch_block_flag = 1'b1;
      rd_chk(8'h02, 8'h04);
      rd_chk(8'h00, 8'h00);
      many_touch_block_flag = 1'b0;
      rd_chk(8'h02, 8'h00);
      $display("lamp and limiter test done");
   endtask
   task t_pattern;
      pen = 1'b1;
      pcm = 1'b1;
      pcnt = 2'd2;
      over = 3'b001;
      rf = 3'b001;
      samp();
      rd_chk(8'h0A, 8'h01);
      rd_chk(8'h02, 8'h00);
      rf = 3'b010;
      samp();
      rd_chk(8'h02, 8'h02);
      rd_chk(8'h00, 8'h00);
      rf = 3'b000;
      samp();
      rd_chk(8'h0A, 8'h00);
      host_u.clr_int();
      rd_chk(8'h02, 8'h00);
      palert = 1'b1;
      rf = 3'b010;
      samp();
      rd_chk(8'h00, 8'h01);
      host_u.clr_int();
      rd_chk(8'h02, 8'h02);
      rf = 3'b000;
      palert = 1'b0;
      pen = 1'b0;
      samp();
      host_u.clr_int();
      $display("pattern test done");
   endtask
   task t_delta;
      base = {3{16'h1000}};
      raw = {3{16'h1100}};
      host_u.wr_reg(8'h1F, 8'h0F);
      samp();
      rd_chk(8'h10, 8'h7F);
      raw = {3{16'h0F00}};
      samp();
      rd_chk(8'h11, 8'h80);
      raw = {3{16'h1040}};
      host_u.wr_reg(8'h1F, 8'h3A);
      samp();
      rd_chk(8'h12, 8'h08);
      host_u.wr_reg(8'h1F, 8'h30);
      raw = {3{16'h1100}};
      rd_chk(8'h10, 8'h08);
      raw = {3{16'h1040}};
      host_u.wr_reg(8'h44, 8'h48);
      lf = 3'b001;
      samp();
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h0A, 8'h00);
      host_u.wr_reg(8'h20, 8'h30);
      samp();
      rd_chk(8'h10, 8'h08);
      lf = 3'b000;
      rf = 3'b001;
      host_u.wr_reg(8'h44, 8'h44);
      samp();
      rd_chk(8'h10, 8'h08);
      rd_chk(8'h0A, 8'h01);
      rf = 3'b000;
      samp();
      rd_chk(8'h10, 8'h00);
      rd_chk(8'h0A, 8'h00);
      host_u.wr_reg(8'h44, 8'h40);
      $display("delta test done");
   endtask
   task t_sleep;
      rf = 3'b001;
      samp();
      rf = 3'b000;
      ev(3'b001, 3'b001);
      host_u.wr_reg(8'h00, 8'hF0);
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h0A, 8'h00);
      rd_chk(8'h02, 8'h00);
      rd_chk(8'h00, 8'hF0);
      host_u.wr_reg(8'h00, 8'h00);
      $display("deep sleep test done");
   endtask
   // Main sequence
   initial begin
      {i_rst, sv, many_touch_block_flag, pen, pcm, palert} = 6'b100000;
      {raw, base} = '0;
      {lf, rf, det, pres, over, lfin, llink} = '0;
      pmask = 3'b011;
      pcnt = 2'd0;
      repeat (2) @(negedge i_sys_clk);
      i_rst = 1'b0;
      t_reset();
      t_touch();
      t_lamp_many_touch_block_flag();
      t_pattern();
      t_delta();
      t_sleep();
      finish_test();
   end
endmodule
